// ### rtl/cpsc_pkg.sv
/*
 Shared constants: timing counts, register map, device states.
 Assumes a 30 ns link clock at the device and a 10 ns host clock.
*/
package cpsc_pkg;

   // ============================================================
   // timing
   localparam longint unsigned LINK_PERIOD_PS = 64'd30000;
   localparam longint unsigned CLK_PERIOD_PS = 64'd10000;
   localparam longint unsigned PS_PER_MS = 64'd1000000000;
   localparam longint unsigned POR_LONG_MS = 64'd100;
   localparam longint unsigned POR_SHORT_MS = 64'd2;
   // least times, rounded up to whole link cycles
   localparam int unsigned POR_LONG_CYCLES =
      int'((POR_LONG_MS * PS_PER_MS + LINK_PERIOD_PS - 64'd1) / LINK_PERIOD_PS);
   localparam int unsigned POR_SHORT_CYCLES =
      int'((POR_SHORT_MS * PS_PER_MS + LINK_PERIOD_PS - 64'd1) / LINK_PERIOD_PS);
   localparam int unsigned POR_CNT_W = 22;
   localparam int unsigned CONFIG_CLOCK_OUT_HALF_CYCLES = 2;
   localparam int unsigned CONFIG_BYTES_DEF = 16;
   localparam int unsigned DONE_WAIT_CYCLES = 8;
   localparam int unsigned EXT_DIV_DEF = 4;

   // ============================================================
   // link values
   localparam logic [2:0] PAGE_DEFAULT = 3'h0;
   localparam int unsigned SYNC_W_DEV = 14;
   localparam int unsigned SYNC_W_HOST = 11;

   // ============================================================
   // host register map
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_JTAG = 12'h008;
   localparam logic [9:0] CTRL_RESET = 10'h000;
   localparam int unsigned CTRL_PAGE_LSB = 0;
   localparam int unsigned CTRL_DELAY_SEL = 3;
   localparam int unsigned CTRL_CS_HIGH = 4;
   localparam int unsigned CTRL_STATUS_PULL = 5;
   localparam int unsigned CTRL_OE_HOLD = 6;
   localparam int unsigned CTRL_EXT_RUN = 7;
   localparam int unsigned CTRL_FPGA_POWER = 8;
   localparam int unsigned CTRL_FORCE_FAIL = 9;
   localparam int unsigned JTAG_TCK = 0;
   localparam int unsigned JTAG_TMS = 1;
   localparam int unsigned JTAG_TDI = 2;
   localparam int unsigned JTAG_TDO = 3;

   // ============================================================
   // device states
   typedef enum logic [2:0] {
      ST_START = 3'b000,
      ST_POR = 3'b001,
      ST_RELEASE = 3'b010,
      ST_LOAD = 3'b011,
      ST_CHECK = 3'b100,
      ST_USER = 3'b101,
      ST_IDLE = 3'b110
   } cpsc_state_e;

endpackage

// ### rtl/cpsc_link_if.sv
/*
 Link between the controller and the FPGA/board end.
 Assumes a pull-up on the shared enable line.
*/
`timescale 1ns/1ps
interface cpsc_link_if;
   logic [2:0] image_page_select;
   logic reset_delay_select;
   logic external_clock_in;
   logic chip_select_low;
   logic fpga_status_low;
   logic config_done_flag;
   logic config_clock_out;
   logic [7:0] config_data;
   logic dev_oe_out;
   logic dev_oe_en;
   logic host_oe_out;
   logic host_oe_en;
   logic oe_line;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;

   // wired-and with pull-up
   assign oe_line = ~((dev_oe_en & ~dev_oe_out) | (host_oe_en & ~host_oe_out));

   modport dev (
      input image_page_select, reset_delay_select, external_clock_in,
      input chip_select_low, fpga_status_low, config_done_flag,
      input oe_line, tck, tms, tdi,
      output config_clock_out, config_data, dev_oe_out, dev_oe_en, tdo
   );
   modport host (
      output image_page_select, reset_delay_select, external_clock_in,
      output chip_select_low, fpga_status_low, config_done_flag,
      output host_oe_out, host_oe_en, tck, tms, tdi,
      input config_clock_out, config_data, oe_line, tdo
   );
endinterface

// ### rtl/cpsc_sync.sv
/*
 Two-stage synchroniser for independent level bits.
 Assumes levels only; words need their own qualifier.
*/
`timescale 1ns/1ps
module cpsc_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bundle
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ### rtl/cpsc_device.sv
/*
 Controller end: power-on delay, enable release, start or idle choice,
 byte stream, bypass test port.
 Assumes the link clock; rst stands for a full power cycle.
*/
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// - three-bit page input picks image, default zero
// - board holds page inputs at defined levels
// - delay 100 ms when select low, 2 ms high
// - drive enable low until supply good, count done
// - reset ends only when enable line goes high
// - host issues no test instructions during reset
// - FPGA status low restarts reset and configuration, except in idle
// - done low after all data means error, reset
// - chip select sampled on enable rising edge
// - chip select high gives static idle state
// - idle held until power cycle
// - FPGA pulls done low before enable release
// - external clock may source configuration clock
// - external clock ignored once in user mode
// - four-wire test port driven by host
module cpsc_device
   import cpsc_pkg::*;
#(
   parameter int unsigned POR_LONG = POR_LONG_CYCLES,
   parameter int unsigned POR_SHORT = POR_SHORT_CYCLES,
   parameter int unsigned CONFIG_BYTES = CONFIG_BYTES_DEF,
   parameter int unsigned DONE_WAIT = DONE_WAIT_CYCLES
) (
   // link clock domain
   input wire logic link_clk,
   input wire logic rst,
   // supply monitor and clock source choice
   input wire logic power_good,
   input wire logic ext_clock_select,
   // status
   output logic [2:0] active_page,
   output logic in_idle,
   output logic in_user_mode,
   output logic config_error,
   // link
   cpsc_link_if.dev link
);

   // ============================================================
   // parameter check
   if (POR_LONG == 0 || POR_SHORT == 0 || POR_LONG > (1 << POR_CNT_W) ||
       POR_SHORT > (1 << POR_CNT_W) || CONFIG_BYTES == 0 || CONFIG_BYTES > 255 ||
       DONE_WAIT == 0 || DONE_WAIT > 255) begin : g_bad_param
      $error("cpsc_device: parameter out of range");
   end

   localparam logic [POR_CNT_W-1:0] POR_LONG_LOAD = POR_CNT_W'(POR_LONG - 1);
   localparam logic [POR_CNT_W-1:0] POR_SHORT_LOAD = POR_CNT_W'(POR_SHORT - 1);
   localparam logic [7:0] LAST_BYTE = 8'(CONFIG_BYTES);
   localparam logic [7:0] WAIT_LOAD = 8'(DONE_WAIT - 1);
   localparam logic [1:0] DIV_LAST = 2'(CONFIG_CLOCK_OUT_HALF_CYCLES - 1);

   // ============================================================
   // pin synchronisers
   logic [2:0] page_s;
   logic delay_sel_s, tdi_s, tms_s, tck_s, ext_s, done_s;
   logic status_s, cs_s, oe_s, ext_sel_s, pgood_s;

   cpsc_sync #(.W(SYNC_W_DEV)) u_sync (
      .clk(link_clk),
      .rst(rst),
      .d({power_good, ext_clock_select, link.oe_line, link.chip_select_low,
          link.fpga_status_low, link.config_done_flag, link.external_clock_in,
          link.tck, link.tms, link.tdi, link.reset_delay_select, link.image_page_select}),
      .q({pgood_s, ext_sel_s, oe_s, cs_s, status_s, done_s, ext_s, tck_s, tms_s, tdi_s,
          delay_sel_s, page_s})
   );

   // ============================================================
   // state machine
   cpsc_state_e state, next_state;
   logic [POR_CNT_W-1:0] por_cnt;
   logic delay_short;
   logic oe_prev, ext_prev;
   logic [7:0] byte_cnt;
   logic [7:0] wait_cnt;
   logic oe_rise, done_fail;

   assign oe_rise = oe_s & ~oe_prev;
   assign done_fail = ~done_s & (wait_cnt == 8'h00);

   always_comb begin
      next_state = state;
      case (state)
         ST_START: next_state = ST_POR;
         ST_POR: begin
            if (pgood_s && por_cnt == '0) begin
               next_state = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            // another party may still hold the line low
            if (oe_rise) begin
               next_state = cs_s ? ST_IDLE : ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (!status_s) begin
               next_state = ST_START;
            end else if (byte_cnt == LAST_BYTE) begin
               next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (!status_s) begin
               next_state = ST_START;
            end else if (done_s) begin
               next_state = ST_USER;
            end else if (done_fail) begin
               next_state = ST_START;
            end
         end
         ST_USER: begin
            if (!status_s) begin
               next_state = ST_START;
            end
         end
         ST_IDLE: next_state = ST_IDLE;
         default: next_state = ST_START;
      endcase
      // loss of supply is the only way out of idle
      if (!pgood_s && state != ST_POR) begin
         next_state = ST_START;
      end
   end

   always_ff @(posedge link_clk) begin
      if (rst) begin
         state <= ST_START;
      end else begin
         state <= next_state;
      end
   end

   // ============================================================
   // power-on delay
   always_ff @(posedge link_clk) begin
      if (rst) begin
         delay_short <= 1'b0;
         por_cnt <= '0;
      end else if (state == ST_START) begin
         delay_short <= delay_sel_s;
         por_cnt <= delay_sel_s ? POR_SHORT_LOAD : POR_LONG_LOAD;
      end else if (state == ST_POR) begin
         // a supply dip restarts the count with the same choice
         if (!pgood_s) begin
            por_cnt <= delay_short ? POR_SHORT_LOAD : POR_LONG_LOAD;
         end else if (por_cnt != '0) begin
            por_cnt <= por_cnt - 1'b1;
         end
      end
   end

   // ============================================================
   // output-enable drive and edge tracking
   always_ff @(posedge link_clk) begin
      if (rst) begin
         link.dev_oe_en <= 1'b1;
         oe_prev <= 1'b0;
         ext_prev <= 1'b0;
      end else begin
         link.dev_oe_en <= (next_state == ST_START) || (next_state == ST_POR);
         oe_prev <= oe_s;
         ext_prev <= ext_s;
      end
   end

   assign link.dev_oe_out = 1'b0;

   always_ff @(posedge link_clk) begin
      if (rst) begin
         active_page <= PAGE_DEFAULT;
      end else if (state == ST_RELEASE && oe_rise) begin
         active_page <= page_s;
      end
   end

   // ============================================================
   // configuration clock and data
   logic [1:0] div_cnt;
   logic tick;

   // external source only counts while loading; user mode never looks at it
   assign tick = ext_sel_s ? (ext_s & ~ext_prev) : (div_cnt == DIV_LAST);

   always_ff @(posedge link_clk) begin
      if (rst) begin
         div_cnt <= '0;
         link.config_clock_out <= 1'b0;
         link.config_data <= 8'h00;
         byte_cnt <= 8'h00;
      end else if (state == ST_LOAD && next_state == ST_LOAD) begin
         div_cnt <= (div_cnt == DIV_LAST) ? 2'h0 : div_cnt + 2'h1;
         if (tick) begin
            link.config_clock_out <= ~link.config_clock_out;
            // data moves on the falling edge so it is settled at the next rise
            if (link.config_clock_out) begin
               byte_cnt <= byte_cnt + 8'h01;
               link.config_data <= {active_page, byte_cnt[4:0] + 5'h01};
            end
         end
      end else if (state == ST_RELEASE) begin
         div_cnt <= '0;
         link.config_clock_out <= 1'b0;
         link.config_data <= {page_s, 5'h00};
         byte_cnt <= 8'h00;
      end else begin
         // idle and user mode keep the pins static
         div_cnt <= '0;
         link.config_clock_out <= 1'b0;
      end
   end

   // ============================================================
   // done check
   always_ff @(posedge link_clk) begin
      if (rst) begin
         wait_cnt <= 8'h00;
         config_error <= 1'b0;
      end else begin
         if (state == ST_LOAD) begin
            wait_cnt <= WAIT_LOAD;
         end else if (state == ST_CHECK && wait_cnt != 8'h00) begin
            wait_cnt <= wait_cnt - 8'h01;
         end
         config_error <= (state == ST_CHECK) && (next_state == ST_START) &&
                         status_s && pgood_s && done_fail;
      end
   end

   assign in_idle = (state == ST_IDLE);
   assign in_user_mode = (state == ST_USER);

   // ============================================================
   // test port: single bypass stage, shifts while mode select is low
   logic tck_prev;

   always_ff @(posedge link_clk) begin
      if (rst) begin
         tck_prev <= 1'b0;
         link.tdo <= 1'b0;
      end else begin
         tck_prev <= tck_s;
         if (tck_s && !tck_prev && !tms_s) begin
            link.tdo <= tdi_s;
         end
      end
   end

endmodule

// ### rtl/cpsc_host.sv
/*
 FPGA and board end of the link, with APB registers and an FPGA model.
 Assumes APB on clk; link inputs come from the link clock, synchronised.
*/
`timescale 1ns/1ps
module cpsc_host
   import cpsc_pkg::*;
#(
   parameter int unsigned DONE_AFTER = CONFIG_BYTES_DEF,
   parameter int unsigned EXT_DIV = EXT_DIV_DEF
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   cpsc_link_if.host link
);

   // ============================================================
   // parameter check
   if (DONE_AFTER == 0 || DONE_AFTER > 65535 || EXT_DIV == 0 || EXT_DIV > 255)
   begin : g_bad_param
      $error("cpsc_host: parameter out of range");
   end

   localparam logic [15:0] DONE_COUNT = 16'(DONE_AFTER);
   localparam logic [7:0] EXT_LAST = 8'(EXT_DIV - 1);

   // ============================================================
   // synchronisers
   logic oe_s, config_clock_out_s, tdo_s;
   logic [7:0] data_s;

   cpsc_sync #(.W(SYNC_W_HOST)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({link.oe_line, link.config_clock_out, link.tdo, link.config_data}),
      .q({oe_s, config_clock_out_s, tdo_s, data_s})
   );

   // ============================================================
   // registers
   logic [9:0] ctrl;
   logic [2:0] jtag;
   logic mapped, wr_en;

   assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_JTAG);
   assign wr_en = psel & penable & pwrite & mapped;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
         jtag <= 3'h0;
      end else if (wr_en) begin
         if (paddr == ADDR_CTRL) begin
            ctrl <= pwdata[9:0];
         end
         if (paddr == ADDR_JTAG) begin
            jtag <= pwdata[2:0];
         end
      end
   end

   // ============================================================
   // fpga model
   logic config_clock_out_prev;
   logic [15:0] rise_cnt;
   logic [7:0] last_byte;
   logic configured;

   assign configured = (rise_cnt >= DONE_COUNT) & ~ctrl[CTRL_FORCE_FAIL];

   always_ff @(posedge clk) begin
      if (rst) begin
         config_clock_out_prev <= 1'b0;
         rise_cnt <= 16'h0000;
         last_byte <= 8'h00;
      end else begin
         config_clock_out_prev <= config_clock_out_s;
         // a device back in reset means a fresh configuration
         if (!oe_s || ctrl[CTRL_STATUS_PULL]) begin
            rise_cnt <= 16'h0000;
         end else if (config_clock_out_s && !config_clock_out_prev) begin
            if (rise_cnt != 16'hFFFF) begin
               rise_cnt <= rise_cnt + 16'h0001;
            end
            last_byte <= data_s;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         link.config_done_flag <= 1'b1;
      end else begin
         // unpowered FPGA leaves done to its pull-up
         link.config_done_flag <= ~ctrl[CTRL_FPGA_POWER] | configured;
      end
   end

   assign link.image_page_select = ctrl[CTRL_PAGE_LSB +: 3];
   assign link.reset_delay_select = ctrl[CTRL_DELAY_SEL];
   assign link.chip_select_low = ctrl[CTRL_CS_HIGH];
   assign link.fpga_status_low = ~ctrl[CTRL_STATUS_PULL];
   assign link.host_oe_out = 1'b0;
   assign link.host_oe_en = ctrl[CTRL_OE_HOLD];

   // ============================================================
   // external clock divider
   logic [7:0] ext_cnt;

   always_ff @(posedge clk) begin
      if (rst) begin
         ext_cnt <= 8'h00;
         link.external_clock_in <= 1'b0;
      end else if (ctrl[CTRL_EXT_RUN]) begin
         ext_cnt <= (ext_cnt == EXT_LAST) ? 8'h00 : ext_cnt + 8'h01;
         if (ext_cnt == EXT_LAST) begin
            link.external_clock_in <= ~link.external_clock_in;
         end
      end else begin
         ext_cnt <= 8'h00;
      end
   end

   // ============================================================
   // test port: clock held low while the device is in reset
   always_ff @(posedge clk) begin
      if (rst) begin
         link.tck <= 1'b0;
         link.tms <= 1'b1;
         link.tdi <= 1'b1;
      end else begin
         link.tck <= jtag[JTAG_TCK] & oe_s;
         link.tms <= jtag[JTAG_TMS];
         link.tdi <= jtag[JTAG_TDI];
      end
   end

   // ============================================================
   // read data, captured in the setup cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         case (paddr)
            ADDR_CTRL: prdata <= {22'h000000, ctrl};
            ADDR_STATUS: prdata <= {rise_cnt, last_byte, 5'h00, tdo_s,
                                    link.config_done_flag, oe_s};
            ADDR_JTAG: prdata <= {28'h0000000, tdo_s, jtag};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

endmodule

// ### test/cpsc_link_asserts.sv
/*
 Link checker in the link clock domain.
 Assumes plain signals from beside the link interface.
*/
`timescale 1ns/1ps
module cpsc_link_asserts #(
   parameter int unsigned POR_SHORT = 20
) (
   // clock, reset, supply
   input wire logic link_clk,
   input wire logic rst,
   input wire logic power_good,
   // link
   input wire logic oe_line,
   input wire logic dev_oe_en,
   input wire logic fpga_status_low,
   input wire logic config_clock_out,
   input wire logic [7:0] config_data,
   // device status
   input wire logic [2:0] active_page,
   input wire logic in_idle,
   input wire logic in_user_mode,
   input wire logic config_error
);
   // ============================================================
   // good-power cycles with enable held low
   int unsigned low_cnt;
   always_ff @(posedge link_clk) begin
      if (rst || !dev_oe_en || !power_good) begin
         low_cnt <= 0;
      end else begin
         low_cnt <= low_cnt + 1;
      end
   end
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (rst);
   // ============================================================
   // properties
   property p_oe_after_reset;
      $fell(rst) |-> dev_oe_en;
   endproperty
   a_oe_after_reset: assert property (p_oe_after_reset) else $error("enable not low at reset");
   property p_por_min;
      $fell(dev_oe_en) |-> low_cnt >= POR_SHORT;
   endproperty
   a_por_min: assert property (p_por_min) else $error("enable released early");
   property p_power_restart;
      $fell(power_good) |-> ##[1:5] dev_oe_en;
   endproperty
   a_power_restart: assert property (p_power_restart) else $error("no reset on supply loss");
   property p_clock_after_release;
      $rose(config_clock_out) |-> $past(oe_line, 2) && !dev_oe_en;
   endproperty
   a_clock_after_release: assert property (p_clock_after_release) else $error("clock in reset");
   property p_page_in_data;
      $rose(config_clock_out) |-> config_data[7:5] == active_page;
   endproperty
   a_page_in_data: assert property (p_page_in_data) else $error("byte of wrong page");
   property p_status_restart;
      $fell(fpga_status_low) && !in_idle |-> ##[1:8] dev_oe_en;
   endproperty
   a_status_restart: assert property (p_status_restart) else $error("status low ignored");
   property p_error_restart;
      config_error |=> !config_error ##[0:1] dev_oe_en;
   endproperty
   a_error_restart: assert property (p_error_restart) else $error("error without reset");
   property p_idle_static;
      in_idle && $past(in_idle) |-> $stable(config_clock_out) && $stable(config_data);
   endproperty
   a_idle_static: assert property (p_idle_static) else $error("pins move in idle");
   property p_idle_hold;
      in_idle && power_good && $past(power_good, 3) |=> in_idle;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle left early");
   property p_user_static;
      in_user_mode && $past(in_user_mode) |-> $stable(config_clock_out) && $stable(config_data);
   endproperty
   a_user_static: assert property (p_user_static) else $error("pins move in user mode");
endmodule

// ### test/tb_config_por_and_start_control.sv
/*
 Bench of both ends on one link.
 Assumes nothing outside; it makes clocks, supply and APB traffic.
*/
`timescale 1ns/1ps
module tb_config_por_and_start_control
   import cpsc_pkg::*;
;
   localparam int unsigned P_LONG = 50;
   localparam int unsigned P_SHORT = 20;
   logic clk = 1'b0, link_clk = 1'b1, rst = 1'b1, power_good = 1'b0, ext_clock_select = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, hit;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hEA1A77F8;
   logic [2:0] active_page, page = 3'h0;
   logic in_idle, in_user_mode, config_error, prev_clk = 1'b0, prev_oe = 1'b0;
   logic [4:0] idx = 5'h00;
   int fail_count = 0, comparisons = 0, cycles = 0, por_len = 0, good_cnt = 0, rises = 0, r0;
   cpsc_link_if link ();
   cpsc_device #(.POR_LONG(P_LONG), .POR_SHORT(P_SHORT))
      cpsc_device_i (.link_clk(link_clk), .rst(rst), .power_good(power_good),
      .ext_clock_select(ext_clock_select), .active_page(active_page), .in_idle(in_idle),
      .in_user_mode(in_user_mode), .config_error(config_error), .link(link.dev));
   cpsc_host cpsc_host_i (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link.host));
   cpsc_link_asserts #(.POR_SHORT(P_SHORT)) cpsc_link_asserts_i (.link_clk(link_clk),
      .rst(rst), .power_good(power_good), .oe_line(link.oe_line), .dev_oe_en(link.dev_oe_en),
      .fpga_status_low(link.fpga_status_low), .config_clock_out(link.config_clock_out),
      .config_data(link.config_data), .active_page(active_page), .in_idle(in_idle),
      .in_user_mode(in_user_mode), .config_error(config_error));
   // ============================================================
   // clocks, timeout, byte model
   always #5 clk = ~clk;
   // starting high keeps the two clocks' rising edges apart
   always #15 link_clk = ~link_clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fail_count = fail_count + 1;
         end_sim();
      end
   end
   always @(posedge link_clk) begin
      prev_clk <= link.config_clock_out;
      prev_oe <= link.oe_line;
      good_cnt <= (power_good && !link.oe_line) ? good_cnt + 1 : 0;
      if (link.oe_line && !prev_oe) por_len <= good_cnt;
      if (!link.oe_line) idx <= 5'h00;
      if (link.config_clock_out && !prev_clk) begin
         chk("byte", {24'h0, link.config_data}, {24'h0, page, idx});
         idx <= idx + 5'h01;
         rises <= rises + 1;
      end
   end
   // ============================================================
   // tasks
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic ctrl(input logic [9:0] v);
      apb(1'b1, ADDR_CTRL, {22'h0, v | {7'h0, page}});
   endtask
   task automatic cycle_power();
      @(posedge link_clk);
      power_good <= 1'b0;
      repeat (8) @(posedge link_clk);
      power_good <= 1'b1;
      r0 = rises;
   endtask
   task automatic wait_for(input int which, input int lim, output logic h);
      h = 1'b0;
      for (int i = 0; i < lim && !h; i++) begin
         @(posedge link_clk);
         h = (which == 0) ? in_user_mode === 1'b1 : (which == 1) ? in_idle === 1'b1 :
            config_error === 1'b1;
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ============================================================
   // scenarios
   initial begin
      repeat (4) @(posedge link_clk);
      @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl_reset", rd, 32'h0);
      apb(1'b1, 12'h010, 32'hFFFFFFFF);
      chk("slverr", {31'h0, err}, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped", rd, 32'h0);
      seed = xs(seed);
      page = seed[2:0];
      ctrl(10'h100);
      cycle_power();
      wait_for(0, 600, hit);
      chk("user", {31'h0, hit}, 32'h1);
      chk("por_long", {31'h0, por_len >= P_LONG && por_len <= P_LONG + 8}, 32'h1);
      chk("page", {29'h0, active_page}, {29'h0, page});
      chk("rises", 32'(rises - r0), 32'h10);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status", rd & 32'hFFFFFF03, {16'h0010, page, 5'h0F, 8'h03});
      $display("test long delay done");
      ctrl(10'h180);
      repeat (40) @(posedge link_clk);
      chk("ext_user", {31'h0, in_user_mode}, 32'h1);
      chk("ext_rises", 32'(rises - r0), 32'h10);
      ctrl(10'h1A0);
      repeat (12) @(posedge link_clk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("restart_oe", {31'h0, rd[0]}, 32'h0);
      r0 = rises;
      ctrl(10'h108);
      wait_for(0, 600, hit);
      chk("reconfig", 32'(rises - r0), 32'h10);
      chk("por_latched", {31'h0, por_len >= P_LONG}, 32'h1);
      $display("test status restart done");
      seed = xs(seed);
      page = seed[2:0];
      ext_clock_select <= 1'b1;
      ctrl(10'h188);
      cycle_power();
      wait_for(0, 600, hit);
      chk("ext_cfg", 32'(rises - r0), 32'h10);
      chk("por_short", {31'h0, por_len >= P_SHORT && por_len <= P_SHORT + 8}, 32'h1);
      ext_clock_select <= 1'b0;
      $display("test external clock done");
      ctrl(10'h148);
      cycle_power();
      repeat (P_LONG + 30) @(posedge link_clk);
      chk("held", {31'h0, in_user_mode}, 32'h0);
      chk("held_rises", 32'(rises - r0), 32'h0);
      ctrl(10'h108);
      wait_for(0, 600, hit);
      chk("after_hold", 32'(rises - r0), 32'h10);
      $display("test oe hold done");
      ctrl(10'h308);
      cycle_power();
      wait_for(2, 900, hit);
      chk("cfg_error", {31'h0, hit}, 32'h1);
      ctrl(10'h108);
      wait_for(0, 900, hit);
      chk("recover", {31'h0, hit}, 32'h1);
      $display("test config error done");
      ctrl(10'h118);
      cycle_power();
      wait_for(1, 600, hit);
      chk("idle", {31'h0, hit}, 32'h1);
      r0 = rises;
      ctrl(10'h128);
      repeat (20) @(posedge link_clk);
      ctrl(10'h108);
      repeat (40) @(posedge link_clk);
      chk("idle_kept", {30'h0, in_idle, in_user_mode}, 32'h2);
      chk("idle_rises", 32'(rises - r0), 32'h0);
      cycle_power();
      wait_for(0, 600, hit);
      chk("idle_exit", {31'h0, hit}, 32'h1);
      $display("test idle done");
      for (int b = 0; b < 4; b++) begin
         seed = xs(seed);
         apb(1'b1, ADDR_JTAG, {29'h0, seed[0], 2'b00});
         apb(1'b1, ADDR_JTAG, {29'h0, seed[0], 2'b01});
         repeat (8) @(posedge link_clk);
         apb(1'b0, ADDR_JTAG, 32'h0);
         chk("tdo", {31'h0, rd[JTAG_TDO]}, {31'h0, seed[0]});
      end
      $display("test test port done");
      end_sim();
   end
endmodule
